// ==== core/bocm_cfg.svh ====
// Constants for the breaker object control block.
// Assumes a 200 MHz system clock and settings given in 20 ms steps.
`ifndef BOCM_CFG_SVH
`define BOCM_CFG_SVH

// System clock rate and millisecond tick
`define BOCM_CLK_HZ 200000000
`define BOCM_TICK_US 1000
`define BOCM_TICK_CYC (`BOCM_CLK_HZ / 1000000 * `BOCM_TICK_US)

// Setting step is 0.02 s, counted in ms ticks
`define BOCM_STEP_MS 5'h14

// Width of every setting and timer, counted in steps
`define BOCM_TW 15

// Recommended settings in steps: 0.2 s, 0.2 s and 10 s
`define BOCM_TRAV_DEF 15'h000a
`define BOCM_PULSE_DEF 15'h000a
`define BOCM_TERM_DEF 15'h01f4
`define BOCM_FT_DEF 15'h000a

// Largest value of a request counter
`define BOCM_CNT_MAX 32'hffffffff

`endif

// ==== core/bocm_pkg.sv ====
// Types for the breaker object control block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "bocm_cfg.svh"

package bocm_pkg;

    // Kind of switchgear object handled
    typedef enum logic [1:0] {
        BOCM_WDCB, BOCM_CB, BOCM_DISC, BOCM_EARTH
    } bocm_type_t;

    // Decoded position; for the cart OPEN is out and CLOSED is in
    typedef enum logic [2:0] {
        POS_INTERM, POS_OPEN, POS_CLOSED, POS_BAD, POS_UNUSED
    } bocm_pos_t;

    typedef enum logic [1:0] {RDY_OFF, RDY_HIGH, RDY_LOW} bocm_ready_t;

    typedef enum logic [1:0] {
        ACC_USER, ACC_OPER, ACC_CONF, ACC_SUPER
    } bocm_access_t;

    typedef enum logic [1:0] {ST_IDLE, ST_OPENING, ST_CLOSING} bocm_fsm_t;

    typedef struct packed {
        logic [31:0] div;
        logic [4:0] sub;
        logic ms;
        logic step;
    } bocm_tick_t;

    typedef struct packed {
        bocm_pos_t status;
        logic [1:0] raw;
        logic [`BOCM_TW-1:0] cnt;
    } bocm_posst_t;

    typedef struct packed {
        bocm_fsm_t fsm;
        logic [`BOCM_TW-1:0] tmr;
        logic [`BOCM_TW-1:0] ft_tmr;
        logic ft;
        logic open_cmd;
        logic close_cmd;
        logic open_fail;
        logic close_fail;
        logic open_allow;
        logic close_allow;
        logic [5:0] req_q;
        logic [31:0] n_open;
        logic [31:0] n_close;
        logic [31:0] n_open_fail;
        logic [31:0] n_close_fail;
    } bocm_ctrl_t;

endpackage : bocm_pkg

`default_nettype wire

// ==== core/bocm_tick_if.sv ====
// Time base bundle: the ms tick and the 20 ms setting step.
// Assumes one producer and any number of listeners on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

interface bocm_tick_if;
    logic ms;
    logic step;
    modport src (output ms, output step);
    modport snk (input ms, input step);
endinterface : bocm_tick_if

`default_nettype wire

// ==== core/bocm_tick.sv ====
// Millisecond tick and setting-step generator.
// Assumes a free running ref_clk_i and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "bocm_cfg.svh"

module bocm_tick #(
    parameter int TICK_CYCLES = `BOCM_TICK_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    bocm_tick_if.src tk
);

    bocm_pkg::bocm_tick_t s;
    bocm_pkg::bocm_tick_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // common ms tick
    always_comb begin
        next_s = s;
        next_s.ms = 1'b0;
        next_s.step = 1'b0;
        if (s.div == 32'(TICK_CYCLES - 1)) begin
            next_s.div = 32'h0;
            next_s.ms = 1'b1;
            if (s.sub == `BOCM_STEP_MS - 5'h1) begin
                next_s.sub = 5'h0;
                next_s.step = 1'b1;
            end else begin
                next_s.sub = s.sub + 5'h1;
            end
        end else begin
            next_s.div = s.div + 32'h1;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tk.ms = s.ms;
    assign tk.step = s.step;

endmodule : bocm_tick

`default_nettype wire

// ==== core/bocm_pos.sv ====
// Two-input position decoder with traverse time filter.
// Assumes inputs synchronous to ref_clk_i and a running step tick.
`timescale 1ns/1ps
`default_nettype none
`include "bocm_cfg.svh"

module bocm_pos (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    bocm_tick_if.snk tk,
    input wire logic en_i,
    input wire logic a_i,
    input wire logic b_i,
    input wire logic [`BOCM_TW-1:0] limit_i,
    output bocm_pkg::bocm_pos_t status_o
);

    bocm_pkg::bocm_posst_t s;
    bocm_pkg::bocm_posst_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // Valid pairs settle at once, odd pairs only after the traverse time
    always_comb begin
        next_s = s;
        next_s.raw = {a_i, b_i};
        if (!en_i) begin
            next_s.status = bocm_pkg::POS_UNUSED;
            next_s.cnt = '0;
        end else begin
            case ({a_i, b_i})
                2'b10: begin
                    next_s.status = bocm_pkg::POS_OPEN;
                    next_s.cnt = '0;
                end
                2'b01: begin
                    next_s.status = bocm_pkg::POS_CLOSED;
                    next_s.cnt = '0;
                end
                default: begin
                    if ({a_i, b_i} != s.raw) begin
                        next_s.cnt = '0;
                    end else if (s.cnt >= limit_i) begin
                        next_s.status = a_i ? bocm_pkg::POS_BAD
                                            : bocm_pkg::POS_INTERM;
                    end else if (tk.step) begin
                        next_s.cnt = s.cnt + 15'h0001;
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign status_o = s.status;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence both_seen_s;
        en_i && a_i && b_i;
    endsequence

    sequence bad_entry_s;
        (status_o == bocm_pkg::POS_BAD)
        && ($past(status_o) != bocm_pkg::POS_BAD);
    endsequence

    bad_both_a: assert property (
        bad_entry_s |-> $past(a_i && b_i))
        else $error("bad status without both inputs");

    bad_after_a: assert property (
        both_seen_s ##1 (both_seen_s and (s.cnt >= limit_i))
        |=> status_o == bocm_pkg::POS_BAD)
        else $error("bad status missing after traverse time");

    interm_none_a: assert property (
        (status_o == bocm_pkg::POS_INTERM)
        && ($past(status_o) != bocm_pkg::POS_INTERM) |-> $past(!a_i && !b_i))
        else $error("intermediate entered with an input active");

endmodule : bocm_pos

`default_nettype wire

// ==== core/bocm_top.sv ====
// Breaker object control: position monitoring, command gating, pulses.
// Assumes all inputs synchronous to ref_clk_i; settings are in 20 ms steps.
//
// How it works
// - Withdrawable type monitors cart and breaker, gates close on checks.
// - Plain breaker gates close on checks, cart reported unused.
// - Disconnector controls; earthing switch only indicates, never commands.
// - Open input high means open, close input high means closed.
// - Cart-in high means inserted, cart-out high means withdrawn.
// - Commands leave as pulses on relay outputs, never steady.
// - Both inputs still high after traverse time gives Bad.
// - Neither input high after traverse time gives Intermediate.
// - Close pulse is cut at its settable maximum length.
// - Open pulse is cut at its own settable maximum length.
// - Pulse ends early once the object reaches the new position.
// - No position change within termination timeout raises fail, ends control.
// - Final trip output lasts set length; zero holds it until the next successful close.
// - With reclosing pending, no final trip after the opening.
// - Panel commands need the selected access level, default configurator.
// - Local open and close inputs act as command sources.
// - Remote and application open and close inputs act as sources.
// - Breaker close refused when sync check is used and permission absent; disconnector close skips it.
// - Breaker close allowed only with readiness at the chosen polarity; disconnector close skips it.
// - Success and fail counters saturate; clear zeros them.
`timescale 1ns/1ps
`default_nettype none
`include "bocm_cfg.svh"

module bocm_top #(
    parameter int TICK_CYCLES = `BOCM_TICK_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire bocm_pkg::bocm_type_t obj_type_i,
    input wire logic open_st_i,
    input wire logic close_st_i,
    input wire logic cart_in_i,
    input wire logic cart_out_i,
    input wire logic ready_i,
    input wire bocm_pkg::bocm_ready_t ready_mode_i,
    input wire logic sync_ok_i,
    input wire logic sync_use_i,
    input wire logic [`BOCM_TW-1:0] traverse_i,
    input wire logic [`BOCM_TW-1:0] close_len_i,
    input wire logic [`BOCM_TW-1:0] open_len_i,
    input wire logic [`BOCM_TW-1:0] term_i,
    input wire logic [`BOCM_TW-1:0] ft_len_i,
    input wire logic ar_pending_i,
    input wire bocm_pkg::bocm_access_t access_req_i,
    input wire bocm_pkg::bocm_access_t panel_level_i,
    input wire logic panel_open_i,
    input wire logic panel_close_i,
    input wire logic local_open_i,
    input wire logic local_close_i,
    input wire logic remote_open_i,
    input wire logic remote_close_i,
    input wire logic app_open_i,
    input wire logic app_close_i,
    input wire logic stats_clear_i,
    output bocm_pkg::bocm_pos_t obj_status_o,
    output bocm_pkg::bocm_pos_t cart_status_o,
    output logic open_cmd_o,
    output logic close_cmd_o,
    output logic final_trip_o,
    output logic open_fail_o,
    output logic close_fail_o,
    output logic open_allowed_o,
    output logic close_allowed_o,
    output logic busy_o,
    output logic [31:0] n_open_o,
    output logic [31:0] n_close_o,
    output logic [31:0] n_open_fail_o,
    output logic [31:0] n_close_fail_o
);

    bocm_pkg::bocm_ctrl_t s;
    bocm_pkg::bocm_ctrl_t next_s;
    logic [5:0] req_now;
    logic [5:0] req_rise;
    logic panel_ok;
    logic open_req;
    logic close_req;
    logic ctrl_ok;
    logic breaker;
    logic ready_ok;
    logic close_ok;

    bocm_tick_if tk ();

    // Saturating counter step
    function automatic logic [31:0] bocm_inc(input logic [31:0] v);
        bocm_inc = (v == `BOCM_CNT_MAX) ? v : v + 32'h1;
    endfunction : bocm_inc

    ////////////////////////////////////////////////////////////////////////
    // Time base
    bocm_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tk(tk.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // breaker position
    bocm_pos u_obj (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tk(tk.snk),
        .en_i(1'b1),
        .a_i(open_st_i),
        .b_i(close_st_i),
        .limit_i(traverse_i),
        .status_o(obj_status_o)
    );

    // cart position, only for the withdrawable type
    bocm_pos u_cart (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tk(tk.snk),
        .en_i(obj_type_i == bocm_pkg::BOCM_WDCB),
        .a_i(cart_out_i),
        .b_i(cart_in_i),
        .limit_i(traverse_i),
        .status_o(cart_status_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Request sources, local, remote and application levels taken on their rising edge; panel inputs used as levels
    assign req_now = {local_open_i, remote_open_i, app_open_i,
                      local_close_i, remote_close_i, app_close_i};
    assign req_rise = req_now & ~s.req_q;
    assign panel_ok = panel_level_i >= access_req_i;
    assign open_req = (|req_rise[5:3]) || (panel_open_i && panel_ok);
    assign close_req = (|req_rise[2:0]) || (panel_close_i && panel_ok);

    ////////////////////////////////////////////////////////////////////////
    // Command permission
    // earthing switch never commands
    assign ctrl_ok = obj_type_i != bocm_pkg::BOCM_EARTH;
    assign breaker = (obj_type_i == bocm_pkg::BOCM_WDCB)
                     || (obj_type_i == bocm_pkg::BOCM_CB);
    assign ready_ok = (ready_mode_i == bocm_pkg::RDY_OFF)
                      || ((ready_mode_i == bocm_pkg::RDY_HIGH) && ready_i)
                      || ((ready_mode_i == bocm_pkg::RDY_LOW) && !ready_i);
    assign close_ok = ctrl_ok
                      && (!breaker || ((!sync_use_i || sync_ok_i) && ready_ok));

    ////////////////////////////////////////////////////////////////////////
    // Control sequence, counters and final trip
    always_comb begin
        next_s = s;
        next_s.open_fail = 1'b0;
        next_s.close_fail = 1'b0;
        next_s.req_q = req_now;
        next_s.open_allow = ctrl_ok;
        next_s.close_allow = close_ok;
        if (tk.step && (s.tmr != '1)) begin
            next_s.tmr = s.tmr + 15'h0001;
        end
        if (tk.step && (s.ft_tmr != '1)) begin
            next_s.ft_tmr = s.ft_tmr + 15'h0001;
        end
        if (s.ft && (ft_len_i != '0) && (s.ft_tmr >= ft_len_i)) begin
            next_s.ft = 1'b0;
        end
        // clear, a same-cycle success still counts
        if (stats_clear_i) begin
            next_s.n_open = '0;
            next_s.n_close = '0;
            next_s.n_open_fail = '0;
            next_s.n_close_fail = '0;
        end
        case (s.fsm)
            bocm_pkg::ST_IDLE: begin
                if (open_req) begin
                    if (ctrl_ok) begin
                        next_s.fsm = bocm_pkg::ST_OPENING;
                        next_s.tmr = '0;
                        next_s.open_cmd = 1'b1;
                    end else begin
                        next_s.open_fail = 1'b1;
                        next_s.n_open_fail = bocm_inc(next_s.n_open_fail);
                    end
                    if (close_req) begin
                        next_s.close_fail = 1'b1;
                        next_s.n_close_fail = bocm_inc(next_s.n_close_fail);
                    end
                end else if (close_req) begin
                    if (close_ok) begin
                        next_s.fsm = bocm_pkg::ST_CLOSING;
                        next_s.tmr = '0;
                        next_s.close_cmd = 1'b1;
                    end else begin
                        next_s.close_fail = 1'b1;
                        next_s.n_close_fail = bocm_inc(next_s.n_close_fail);
                    end
                end
            end
            bocm_pkg::ST_OPENING: begin
                if (obj_status_o == bocm_pkg::POS_OPEN) begin
                    next_s.open_cmd = 1'b0;
                    next_s.fsm = bocm_pkg::ST_IDLE;
                    next_s.n_open = bocm_inc(next_s.n_open);
                    if (!ar_pending_i) begin
                        next_s.ft = 1'b1;
                        next_s.ft_tmr = '0;
                    end
                end else if (s.tmr >= term_i) begin
                    next_s.open_cmd = 1'b0;
                    next_s.fsm = bocm_pkg::ST_IDLE;
                    next_s.open_fail = 1'b1;
                    next_s.n_open_fail = bocm_inc(next_s.n_open_fail);
                end else if (s.tmr >= open_len_i) begin
                    next_s.open_cmd = 1'b0;
                end
            end
            bocm_pkg::ST_CLOSING: begin
                if (obj_status_o == bocm_pkg::POS_CLOSED) begin
                    next_s.close_cmd = 1'b0;
                    next_s.fsm = bocm_pkg::ST_IDLE;
                    next_s.n_close = bocm_inc(next_s.n_close);
                    next_s.ft = 1'b0;
                end else if (s.tmr >= term_i) begin
                    next_s.close_cmd = 1'b0;
                    next_s.fsm = bocm_pkg::ST_IDLE;
                    next_s.close_fail = 1'b1;
                    next_s.n_close_fail = bocm_inc(next_s.n_close_fail);
                end else if (s.tmr >= close_len_i) begin
                    next_s.close_cmd = 1'b0;
                end
            end
            default: begin
                next_s.fsm = bocm_pkg::ST_IDLE;
                next_s.open_cmd = 1'b0;
                next_s.close_cmd = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign open_cmd_o = s.open_cmd;
    assign close_cmd_o = s.close_cmd;
    assign final_trip_o = s.ft;
    assign open_fail_o = s.open_fail;
    assign close_fail_o = s.close_fail;
    assign open_allowed_o = s.open_allow;
    assign close_allowed_o = s.close_allow;
    assign busy_o = s.fsm != bocm_pkg::ST_IDLE;
    assign n_open_o = s.n_open;
    assign n_close_o = s.n_close;
    assign n_open_fail_o = s.n_open_fail;
    assign n_close_fail_o = s.n_close_fail;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence idle_s;
        s.fsm == bocm_pkg::ST_IDLE;
    endsequence

    sequence close_try_s;
        idle_s and (!open_req && close_req);
    endsequence

    cmd_exclusive_a: assert property (
        !(open_cmd_o && close_cmd_o))
        else $error("open and close commands together");

    earth_no_cmd_a: assert property (
        idle_s and (obj_type_i == bocm_pkg::BOCM_EARTH)
        |=> !open_cmd_o && !close_cmd_o)
        else $error("earthing switch issued a command");

    sync_gate_a: assert property (
        close_try_s and (breaker && sync_use_i && !sync_ok_i)
        |=> !close_cmd_o && close_fail_o)
        else $error("close passed without sync permission");

    ready_gate_a: assert property (
        close_try_s and (breaker && !ready_ok)
        |=> !close_cmd_o && close_fail_o)
        else $error("close passed without readiness");

    open_wins_a: assert property (
        idle_s and (open_req && close_req && ctrl_ok)
        |=> open_cmd_o && !close_cmd_o && close_fail_o)
        else $error("simultaneous requests not resolved to open");

    early_end_a: assert property (
        open_cmd_o && (obj_status_o == bocm_pkg::POS_OPEN)
        |=> !open_cmd_o && !busy_o)
        else $error("open pulse held after position reached");

    pulse_cap_a: assert property (
        close_cmd_o && (s.tmr >= close_len_i) |=> !close_cmd_o)
        else $error("close pulse over its limit");

    term_fail_a: assert property (
        (s.fsm == bocm_pkg::ST_OPENING)
        && (obj_status_o != bocm_pkg::POS_OPEN) && (s.tmr >= term_i)
        |=> open_fail_o && !busy_o)
        else $error("timeout did not end the open control");

    stats_clear_a: assert property (
        stats_clear_i |=> (n_open_o <= 32'h1) && (n_close_fail_o <= 32'h1))
        else $error("counters not cleared");

endmodule : bocm_top

`default_nettype wire

// ==== test/bocm_brk_model.sv ====
// Behavioural breaker answering the relay command pulses.
// Assumes commands synchronous to ref_clk_i; starts in the closed position.
`timescale 1ns/1ps
`default_nettype none

module bocm_brk_model #(
    parameter int DLY = 40
) (
    input wire logic ref_clk_i,
    input wire logic open_cmd_i,
    input wire logic close_cmd_i,
    input wire logic stall_i,
    output logic open_st_o,
    output logic close_st_o,
    output logic ready_o
);
    int cnt = 0;
    logic op = 1'b0;
    logic cl = 1'b1;

    // Contact state drives both status lines
    assign open_st_o = op;
    assign close_st_o = cl;

    // ready when charged
    // Spring counts as charged only while resting open
    assign ready_o = op & ~cl;

    // Contacts move after DLY cycles of command; stall models a stuck drive
    always @(posedge ref_clk_i) begin
        if ((open_cmd_i || close_cmd_i) && !stall_i) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
        if (cnt == DLY) begin
            op <= open_cmd_i;
            cl <= close_cmd_i;
        end
    end
endmodule : bocm_brk_model

`default_nettype wire

// ==== test/bocm_tb.sv ====
// Self-checking bench for the breaker object control block.
// Assumes the package, header and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module bocm_tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] src = 8'h00;
    logic stall = 1'b0, sync_use = 1'b0, sync_ok = 1'b0, clr = 1'b0;
    logic cart_in = 1'b1, cart_out = 1'b0, ar_pend = 1'b0;
    logic [14:0] trav = 15'h0002, plen = 15'h0003, term = 15'h0005;
    bocm_pkg::bocm_type_t otype = bocm_pkg::BOCM_WDCB;
    bocm_pkg::bocm_ready_t rmode = bocm_pkg::RDY_OFF;
    bocm_pkg::bocm_access_t lvl = bocm_pkg::ACC_CONF;
    logic open_st, close_st, ready, open_cmd, close_cmd, ftrip, busy;
    logic ofail, cfail, oallow, callow;
    bocm_pkg::bocm_pos_t obj_st, cart_st;
    logic [31:0] n_op, n_cl, n_opf, n_clf;
    int n_errors = 0;
    int tests_run = 0;
    int n_ofp = 0, n_cfp = 0, n_ocyc = 0, oc0 = 0;

    // 200 MHz clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    bocm_brk_model brk (.ref_clk_i(ref_clk_i), .open_cmd_i(open_cmd),
        .close_cmd_i(close_cmd), .stall_i(stall), .open_st_o(open_st),
        .close_st_o(close_st), .ready_o(ready));

    // Short tick so one 20 ms step is 80 cycles
    bocm_top #(.TICK_CYCLES(4)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .obj_type_i(otype), .open_st_i(open_st), .close_st_i(close_st),
        .cart_in_i(cart_in), .cart_out_i(cart_out), .ready_i(ready),
        .ready_mode_i(rmode), .sync_ok_i(sync_ok), .sync_use_i(sync_use),
        .traverse_i(trav), .close_len_i(plen), .open_len_i(plen),
        .term_i(term), .ft_len_i(trav), .ar_pending_i(ar_pend),
        .access_req_i(bocm_pkg::ACC_CONF), .panel_level_i(lvl),
        .panel_open_i(src[6]), .panel_close_i(src[7]),
        .local_open_i(src[0]), .local_close_i(src[1]),
        .remote_open_i(src[2]), .remote_close_i(src[3]),
        .app_open_i(src[4]), .app_close_i(src[5]), .stats_clear_i(clr),
        .obj_status_o(obj_st), .cart_status_o(cart_st),
        .open_cmd_o(open_cmd), .close_cmd_o(close_cmd),
        .final_trip_o(ftrip), .open_fail_o(ofail), .close_fail_o(cfail),
        .open_allowed_o(oallow), .close_allowed_o(callow), .busy_o(busy),
        .n_open_o(n_op), .n_close_o(n_cl), .n_open_fail_o(n_opf),
        .n_close_fail_o(n_clf));

    // Count fail pulses and open drive cycles in mid-cycle
    always @(negedge ref_clk_i) begin
        n_ofp <= n_ofp + int'(ofail === 1'b1);
        n_cfp <= n_cfp + int'(cfail === 1'b1);
        n_ocyc <= n_ocyc + int'(open_cmd === 1'b1);
    end

    // Compare one value and count it
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Print counts and verdict, then stop
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Raise request sources for one cycle, then wait for idle
    task automatic run(input logic [7:0] m, input string tname);
        int i;
        repeat (20) @(posedge ref_clk_i);
        #1;
        src = m;
        @(posedge ref_clk_i);
        #1;
        src = 8'h00;
        repeat (3) @(posedge ref_clk_i);
        i = 0;
        while (busy !== 1'b0 && i < 3000) begin
            @(posedge ref_clk_i);
            i++;
        end
        if (i == 3000) begin
            n_errors++;
            wrap_up();
        end
        repeat (3) @(posedge ref_clk_i);
        #1;
        $display("test %s done", tname);
    endtask : run

    // Hang guard
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        n_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        check("open_cmd", open_cmd, 32'h0);
        check("n_open", n_op, 32'h0);
        repeat (4) @(posedge ref_clk_i);
        #1;
        check("obj_status", obj_st, bocm_pkg::POS_CLOSED);
        check("cart_status", cart_st, bocm_pkg::POS_CLOSED);
        check("open_allowed", oallow, 32'h1);
        check("close_allowed", callow, 32'h1);
        run(8'h01, "local_open");
        check("obj_status", obj_st, bocm_pkg::POS_OPEN);
        check("n_open", n_op, 32'h1);
        check("final_trip", ftrip, 32'h1);
        repeat (300) @(posedge ref_clk_i);
        #1;
        check("final_trip", ftrip, 32'h0);
        sync_use = 1'b1;
        run(8'h08, "close_no_sync");
        check("n_close_fail", n_clf, 32'h1);
        check("obj_status", obj_st, bocm_pkg::POS_OPEN);
        check("close_allowed", callow, 32'h0);
        // permission only when closing is allowed
        sync_ok = 1'b1;
        rmode = bocm_pkg::RDY_HIGH;
        run(8'h20, "app_close");
        check("n_close", n_cl, 32'h1);
        check("obj_status", obj_st, bocm_pkg::POS_CLOSED);
        ar_pend = 1'b1;
        run(8'h03, "open_and_close");
        check("n_open", n_op, 32'h2);
        check("n_close_fail", n_clf, 32'h2);
        check("final_trip", ftrip, 32'h0);
        run(8'h80, "panel_close");
        check("n_close", n_cl, 32'h2);
        lvl = bocm_pkg::ACC_OPER;
        run(8'h40, "panel_denied");
        check("n_open", n_op, 32'h2);
        check("obj_status", obj_st, bocm_pkg::POS_CLOSED);
        cart_in = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check("cart_status", cart_st, bocm_pkg::POS_CLOSED);
        repeat (200) @(posedge ref_clk_i);
        #1;
        check("cart_status", cart_st, bocm_pkg::POS_INTERM);
        cart_in = 1'b1;
        cart_out = 1'b1;
        repeat (200) @(posedge ref_clk_i);
        #1;
        check("cart_status", cart_st, bocm_pkg::POS_BAD);
        cart_out = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check("cart_status", cart_st, bocm_pkg::POS_CLOSED);
        $display("test cart_traverse done");
        otype = bocm_pkg::BOCM_CB;
        stall = 1'b1;
        oc0 = n_ocyc;
        run(8'h01, "open_stalled");
        oc0 = n_ocyc - oc0;
        check("n_open_fail", n_opf, 32'h1);
        check("open_cmd", open_cmd, 32'h0);
        check("open_pulse_len", oc0 > 160 && oc0 < 242, 32'h1);
        check("cart_status", cart_st, bocm_pkg::POS_UNUSED);
        stall = 1'b0;
        otype = bocm_pkg::BOCM_EARTH;
        run(8'h01, "earth_open");
        check("n_open_fail", n_opf, 32'h2);
        check("obj_status", obj_st, bocm_pkg::POS_CLOSED);
        check("open_allowed", oallow, 32'h0);
        check("open_fail_pulses", n_ofp, 32'h2);
        check("close_fail_pulses", n_cfp, 32'h2);
        clr = 1'b1;
        @(posedge ref_clk_i);
        #1;
        clr = 1'b0;
        @(posedge ref_clk_i);
        #1;
        check("n_open", n_op, 32'h0);
        check("n_close_fail", n_clf, 32'h0);
        $display("test clear done");
        wrap_up();
    end
endmodule : bocm_tb

`default_nettype wire
